// ---- rtl/lsa_pkg.sv ----
// package: constants, register map and types for the line scan trigger block
package lsa_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned MIN_PULSE_NS    = 1000;
  localparam int unsigned MIN_PULSE_CYC   = (MIN_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned MAX_RATE_HZ     = 18000;
  localparam int unsigned MIN_PERIOD_CYC  = (CLK_HZ + MAX_RATE_HZ - 1) / MAX_RATE_HZ;
  localparam int unsigned FILT_W          = 8;
  localparam int unsigned CNT_W           = 24;

  localparam logic [3:0]  ADDR_CMD        = 4'h0;
  localparam logic [3:0]  ADDR_FRAME_CFG  = 4'h1;
  localparam logic [3:0]  ADDR_LINE_CFG   = 4'h2;
  localparam logic [3:0]  ADDR_PERIOD     = 4'h3;
  localparam logic [3:0]  ADDR_HEIGHT     = 4'h4;
  localparam logic [3:0]  ADDR_STROBE     = 4'h5;
  localparam logic [3:0]  ADDR_STATUS     = 4'h6;
  localparam logic [3:0]  ADDR_LINES      = 4'h7;
  localparam logic [3:0]  ADDR_ID         = 4'h8;
  // arbitrary identification value
  localparam logic [31:0] ID_VALUE        = 32'h0001_5ca0;

  localparam int unsigned CMD_START_BIT   = 0;
  localparam int unsigned CMD_STOP_BIT    = 1;

  localparam logic [CNT_W-1:0] PERIOD_RST = 24'h001388;
  localparam logic [15:0]      HEIGHT_RST = 16'h0400;
  localparam logic [15:0]      STROBE_RST = 16'h0064;

  typedef enum logic [2:0] {
    ACT_RISE  = 3'b000,
    ACT_FALL  = 3'b001,
    ACT_ANY   = 3'b010,
    ACT_HIGH  = 3'b011,
    ACT_LOW   = 3'b100
  } lsa_act_t;

  typedef struct packed {
    logic     mode_on;
    logic     source_b;
    lsa_act_t act;
  } lsa_trig_cfg_t;

  typedef enum logic [1:0] {
    GATE_IDLE  = 2'b00,
    GATE_OPEN  = 2'b01,
    GATE_WAIT  = 2'b10
  } lsa_gate_t;

  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } lsa_av_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } lsa_av_rsp_t;
endpackage

// ---- rtl/lsa_trig_filter.sv ----
// input conditioner: synchroniser plus minimum pulse width filter
`timescale 1ns/1ps
`default_nettype none
module lsa_trig_filter (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic raw_in,
  output var  logic clean
);
  typedef struct packed {
    logic                           s1;
    logic                           s2;
    logic                           level;
    logic [lsa_pkg::FILT_W-1:0]     cnt;
  } lsa_filt_st_t;

  lsa_filt_st_t st_reg;
  lsa_filt_st_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = raw_in;
    st_next.s2 = st_reg.s1; // R19
    // level only flips after the new value held for the full minimum width
    if (st_reg.s2 == st_reg.level) begin
      st_next.cnt = '0; // R1
    end else if (st_reg.cnt == lsa_pkg::FILT_W'(lsa_pkg::MIN_PULSE_CYC - 1)) begin
      st_next.level = st_reg.s2; // R1
      st_next.cnt   = '0;
    end else begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign clean = st_reg.level;
endmodule
`default_nettype wire

// ---- rtl/lsa_trigger_ctrl.sv ----
// acquisition and trigger control with avalon-mm register slave
// Operation
// R1: trigger pulses shorter than one microsecond are discarded.
// R2: two independent external trigger lines, each selectable for frame or line.
// R3: strobe output pulse is synchronised with the internal line start.
// R4: no lines are acquired before an acquisition start command.
// R5: acquisition stop immediately ends the ability to acquire.
// R6: only continuous mode; start stays in force until stop.
// R7: after stop, nothing is acquired until a new start arrives.
// R8: line starts act only while the frame gate is valid.
// R9: frame trigger source selectable: internal, line a or line b.
// R10: frame trigger mode has two values, off and on.
// R11: with frame mode off, gate opens as soon as start arrives.
// R12: internal gate stays valid until a frame of lines completes.
// R13: internal gate reopens automatically for the next frame, indefinitely.
// R14: stop forces the gate invalid until acquisition restarts.
// R15: edge activation opens gate on edge until a frame is done.
// R16: level activation holds gate valid while input is at that level; the code opens it only on an edge into that level.
// R17: line mode off generates lines at programmed rate clamped to maximum.
// R18: line mode on starts one line per selected edge on chosen input.
// R19: external inputs are synchronised before width check or edge detection.
// R20: frame height in lines is a configurable count closing the gate.
`timescale 1ns/1ps
`default_nettype none
module lsa_trigger_ctrl (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire lsa_pkg::lsa_av_req_t av_req,
  output var  lsa_pkg::lsa_av_rsp_t av_rsp,
  input  wire logic                 ext_trig_line_a,
  input  wire logic                 ext_trig_line_b,
  output var  logic                 strobe_out,
  output var  logic                 line_start,
  output var  logic                 frame_valid
);
  typedef struct packed {
    logic                              acq_on;
    lsa_pkg::lsa_trig_cfg_t            frame_cfg;
    lsa_pkg::lsa_trig_cfg_t            line_cfg;
    logic [lsa_pkg::CNT_W-1:0]         period;
    logic [15:0]                       height;
    logic [15:0]                       strobe_w;
    lsa_pkg::lsa_gate_t                gate;
    logic [15:0]                       line_cnt;
    logic [lsa_pkg::CNT_W-1:0]         rate_cnt;
    logic [15:0]                       strobe_cnt;
    logic                              strobe;
    logic                              line_pulse;
    logic                              a_d;
    logic                              b_d;
    logic                              ack;
    logic [31:0]                       rdata;
    logic [31:0]                       lines_total;
  } lsa_st_t;

  lsa_st_t st_reg;
  lsa_st_t st_next;
  logic    a_clean;
  logic    b_clean;

  lsa_trig_filter u_filt_a (
    .clk    (clk),
    .resetn (resetn),
    .raw_in (ext_trig_line_a),
    .clean  (a_clean)
  );

  lsa_trig_filter u_filt_b (
    .clk    (clk),
    .resetn (resetn),
    .raw_in (ext_trig_line_b),
    .clean  (b_clean)
  );

  // edge match for a given activation, used for both frame and line triggers
  function automatic logic edge_hit(input lsa_pkg::lsa_act_t act, input logic cur, input logic prev);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = ~cur & prev;
    case (act)
      lsa_pkg::ACT_RISE: edge_hit = rise;
      lsa_pkg::ACT_FALL: edge_hit = fall;
      lsa_pkg::ACT_ANY:  edge_hit = rise | fall;
      lsa_pkg::ACT_HIGH: edge_hit = rise;
      lsa_pkg::ACT_LOW:  edge_hit = fall;
      default:           edge_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] cfg_word(input lsa_pkg::lsa_trig_cfg_t c);
    cfg_word = {27'h0, c};
  endfunction

  logic                      f_cur;
  logic                      f_prev;
  logic                      l_cur;
  logic                      l_prev;
  logic                      f_edge;
  logic                      l_edge;
  logic                      f_level;
  logic                      wr_hit;
  logic                      rd_hit;
  logic                      start_cmd;
  logic                      stop_cmd;
  logic                      fire;
  logic                      frame_done;
  logic [lsa_pkg::CNT_W-1:0] eff_period;

  always_comb begin
    st_next            = st_reg;
    st_next.line_pulse = 1'b0;
    wr_hit    = av_req.write & ~st_reg.ack;
    rd_hit    = av_req.read & ~st_reg.ack;
    start_cmd = wr_hit && av_req.address == lsa_pkg::ADDR_CMD
                && av_req.writedata[lsa_pkg::CMD_START_BIT];
    stop_cmd  = wr_hit && av_req.address == lsa_pkg::ADDR_CMD
                && av_req.writedata[lsa_pkg::CMD_STOP_BIT];
    // either line may feed either trigger
    f_cur  = st_reg.frame_cfg.source_b ? b_clean : a_clean; // R2 R9
    f_prev = st_reg.frame_cfg.source_b ? st_reg.b_d : st_reg.a_d;
    l_cur  = st_reg.line_cfg.source_b ? b_clean : a_clean; // R2
    l_prev = st_reg.line_cfg.source_b ? st_reg.b_d : st_reg.a_d;
    f_edge = edge_hit(st_reg.frame_cfg.act, f_cur, f_prev);
    l_edge = edge_hit(st_reg.line_cfg.act, l_cur, l_prev);
    f_level = (st_reg.frame_cfg.act == lsa_pkg::ACT_HIGH) ||
              (st_reg.frame_cfg.act == lsa_pkg::ACT_LOW);
    st_next.a_d = a_clean;
    st_next.b_d = b_clean;
    // programmed period never below the fastest allowed line period
    eff_period = (st_reg.period < lsa_pkg::CNT_W'(lsa_pkg::MIN_PERIOD_CYC)) ?
                 lsa_pkg::CNT_W'(lsa_pkg::MIN_PERIOD_CYC) : st_reg.period; // R17
    frame_done = 1'b0;
    fire       = 1'b0;

    // line trigger generation
    if (st_reg.line_cfg.mode_on) begin
      fire = l_edge; // R18
      st_next.rate_cnt = '0;
    end else if (st_reg.acq_on) begin
      if (st_reg.rate_cnt >= eff_period - 1'b1) begin
        st_next.rate_cnt = '0;
        fire = 1'b1; // R17
      end else begin
        st_next.rate_cnt = st_reg.rate_cnt + 1'b1;
      end
    end else begin
      st_next.rate_cnt = '0;
    end
    // a line racing a stop write would pulse the strobe with no line behind it
    fire = fire & st_reg.acq_on & (st_reg.gate == lsa_pkg::GATE_OPEN) & ~stop_cmd; // R4 R5 R8

    if (fire) begin
      st_next.line_pulse  = 1'b1;
      st_next.strobe      = 1'b1; // R3
      st_next.strobe_cnt  = st_reg.strobe_w;
      st_next.lines_total = st_reg.lines_total + 1'b1;
      if (st_reg.line_cnt + 1'b1 >= st_reg.height) begin
        frame_done       = 1'b1; // R20
        st_next.line_cnt = '0;
      end else begin
        st_next.line_cnt = st_reg.line_cnt + 1'b1;
      end
    end else if (st_reg.strobe_cnt > 16'h0001) begin
      st_next.strobe_cnt = st_reg.strobe_cnt - 1'b1;
    end else begin
      st_next.strobe_cnt = '0;
      st_next.strobe     = 1'b0;
    end

    // frame gate
    case (st_reg.gate)
      lsa_pkg::GATE_IDLE: begin
        if (st_reg.acq_on) begin
          if (!st_reg.frame_cfg.mode_on) begin
            st_next.gate = lsa_pkg::GATE_OPEN; // R10 R11
          end else begin
            st_next.gate = lsa_pkg::GATE_WAIT;
          end
        end
      end
      lsa_pkg::GATE_WAIT: begin
        if (!st_reg.frame_cfg.mode_on) begin
          st_next.gate = lsa_pkg::GATE_OPEN; // R13
        end else if (f_edge) begin
          st_next.gate = lsa_pkg::GATE_OPEN; // R15 R16
        end
      end
      lsa_pkg::GATE_OPEN: begin
        if (st_reg.frame_cfg.mode_on && f_level) begin
          // level mode ignores frame height and follows the input
          if ((st_reg.frame_cfg.act == lsa_pkg::ACT_HIGH) != f_cur) begin
            st_next.gate     = lsa_pkg::GATE_WAIT; // R16
            st_next.line_cnt = '0;
          end
        end else if (frame_done) begin
          // internal mode reopens on the next cycle, giving one idle gap
          st_next.gate = lsa_pkg::GATE_WAIT; // R12 R15
        end
      end
      default: st_next.gate = lsa_pkg::GATE_IDLE;
    endcase

    // host commands; stop wins when both bits are written together
    if (start_cmd) begin
      st_next.acq_on = 1'b1; // R6
    end
    if (stop_cmd) begin
      st_next.acq_on     = 1'b0; // R5 R7
      st_next.gate       = lsa_pkg::GATE_IDLE; // R14
      st_next.line_cnt   = '0;
      st_next.line_pulse = 1'b0;
    end else if (!st_reg.acq_on && !start_cmd) begin
      st_next.gate = lsa_pkg::GATE_IDLE; // R14
    end

    // register writes and reads
    st_next.ack = (av_req.read | av_req.write) & ~st_reg.ack;
    if (wr_hit) begin
      case (av_req.address)
        lsa_pkg::ADDR_FRAME_CFG: st_next.frame_cfg = av_req.writedata[4:0];
        lsa_pkg::ADDR_LINE_CFG:  st_next.line_cfg  = av_req.writedata[4:0];
        lsa_pkg::ADDR_PERIOD:    st_next.period    = av_req.writedata[lsa_pkg::CNT_W-1:0];
        lsa_pkg::ADDR_HEIGHT:    st_next.height    = av_req.writedata[15:0];
        lsa_pkg::ADDR_STROBE:    st_next.strobe_w  = av_req.writedata[15:0];
        default: ;
      endcase
    end
    if (rd_hit) begin
      case (av_req.address)
        lsa_pkg::ADDR_FRAME_CFG: st_next.rdata = cfg_word(st_reg.frame_cfg);
        lsa_pkg::ADDR_LINE_CFG:  st_next.rdata = cfg_word(st_reg.line_cfg);
        lsa_pkg::ADDR_PERIOD:    st_next.rdata = {8'h0, st_reg.period};
        lsa_pkg::ADDR_HEIGHT:    st_next.rdata = {16'h0, st_reg.height};
        lsa_pkg::ADDR_STROBE:    st_next.rdata = {16'h0, st_reg.strobe_w};
        lsa_pkg::ADDR_STATUS:    st_next.rdata = {12'h0, st_reg.line_cnt, b_clean, a_clean,
                                                  st_reg.gate == lsa_pkg::GATE_OPEN, st_reg.acq_on};
        lsa_pkg::ADDR_LINES:     st_next.rdata = st_reg.lines_total;
        lsa_pkg::ADDR_ID:        st_next.rdata = lsa_pkg::ID_VALUE;
        default:                 st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg          <= '0;
      st_reg.period   <= lsa_pkg::PERIOD_RST;
      st_reg.height   <= lsa_pkg::HEIGHT_RST;
      st_reg.strobe_w <= lsa_pkg::STROBE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // one wait state: waitrequest drops on the cycle after the request appears
  assign av_rsp.waitrequest = (av_req.read | av_req.write) & ~st_reg.ack;
  assign av_rsp.readdata    = st_reg.rdata;
  assign strobe_out         = st_reg.strobe;
  assign line_start         = st_reg.line_pulse;
  assign frame_valid        = st_reg.gate == lsa_pkg::GATE_OPEN;
endmodule
`default_nettype wire

// ---- tb/lsa_trig_src.sv ----
// external trigger source driving both trigger lines
`timescale 1ns/1ps
`default_nettype none
module lsa_trig_src (
  input  wire logic clk,
  output var  logic line_a,
  output var  logic line_b
);
  initial begin
    line_a = 1'b0;
    line_b = 1'b0;
  end
  // whole cycles only; a level lasts at least hold plus one cycles, so holds under 99 cycles probe the glitch filter
  task automatic drive(input logic sel_b, input logic level, input int hold);
    @(posedge clk);
    if (sel_b) begin
      line_b <= level;
    end else begin
      line_a <= level;
    end
    repeat (hold) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- tb/lsa_trigger_ctrl_assertions.sv ----
// port checker for the trigger controller
`timescale 1ns/1ps
`default_nettype none
module lsa_trigger_ctrl_assertions (
  input wire logic                 clk,
  input wire logic                 resetn,
  input wire lsa_pkg::lsa_av_req_t av_req,
  input wire lsa_pkg::lsa_av_rsp_t av_rsp,
  input wire logic                 ext_trig_line_a,
  input wire logic                 ext_trig_line_b,
  input wire logic                 strobe_out,
  input wire logic                 line_start,
  input wire logic                 frame_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic req;
  logic stop_acc;
  logic start_req;
  logic shut;
  assign req = av_req.read | av_req.write;
  assign start_req = av_req.write & (av_req.address == lsa_pkg::ADDR_CMD)
                     & av_req.writedata[lsa_pkg::CMD_START_BIT] & ~av_req.writedata[lsa_pkg::CMD_STOP_BIT];
  // stopped with no start request since; a restart legally reopens the gate
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shut <= 1'b0;
    end else if (stop_acc) begin
      shut <= 1'b1;
    end else if (start_req) begin
      shut <= 1'b0;
    end
  end
  assign stop_acc = av_req.write & ~av_rsp.waitrequest & (av_req.address == lsa_pkg::ADDR_CMD)
                    & av_req.writedata[lsa_pkg::CMD_STOP_BIT];
  a_bus_first_wait: assert property ($rose(req) |-> av_rsp.waitrequest)
    else $error("no wait cycle");
  a_bus_one_wait: assert property ($rose(req) |=> !av_rsp.waitrequest)
    else $error("wait too long");
  a_line_in_gate: assert property (line_start |-> $past(frame_valid))
    else $error("line outside gate");
  a_strobe_at_line: assert property (line_start |-> strobe_out)
    else $error("strobe missing");
  a_strobe_has_cause: assert property ($rose(strobe_out) |-> line_start)
    else $error("strobe without line");
  a_line_one_cycle: assert property (line_start |=> !line_start)
    else $error("line pulse too long");
  a_stop_gate_shut: assert property (shut |-> !frame_valid)
    else $error("gate open after stop");
  a_stop_no_lines: assert property (shut |-> !line_start)
    else $error("line after stop");
endmodule
bind lsa_trigger_ctrl lsa_trigger_ctrl_assertions lsa_trigger_ctrl_assertions_inst (.clk, .resetn, .av_req,
  .av_rsp, .ext_trig_line_a, .ext_trig_line_b, .strobe_out, .line_start, .frame_valid);
`default_nettype wire

// ---- tb/line_scan_acquisition_trigger_tb_top.sv ----
// testbench for the line scan acquisition and trigger controller
`timescale 1ns/1ps
`default_nettype none
module line_scan_acquisition_trigger_tb_top;
  logic                 clk;
  logic                 resetn;
  lsa_pkg::lsa_av_req_t av_req;
  lsa_pkg::lsa_av_rsp_t av_rsp;
  logic                 line_a;
  logic                 line_b;
  logic                 strobe_out;
  logic                 line_start;
  logic                 frame_valid;
  logic [31:0]          rd;
  int                   bad_count;
  int                   n_tests;
  int                   nls;
  int                   shi;
  lsa_trigger_ctrl lsa_trigger_ctrl_inst (.clk, .resetn, .av_req, .av_rsp, .ext_trig_line_a(line_a),
    .ext_trig_line_b(line_b), .strobe_out, .line_start, .frame_valid);
  lsa_trig_src lsa_trig_src_inst (.clk, .line_a, .line_b);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  always @(posedge clk) begin
    if (line_start === 1'b1) begin
      nls++;
      check("strobe", 1, strobe_out);
    end
    if (strobe_out === 1'b1) begin
      shi++;
    end else if (shi != 0) begin
      check("strobe width", lsa_pkg::STROBE_RST, shi);
      shi = 0;
    end
  end
  // waits as long as the slave asks; only the watchdog ends a stuck transfer
  task automatic av(input logic [3:0] a, input logic wr, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    av_req <= '{address: a, read: !wr, write: wr, writedata: d};
    do begin
      @(posedge clk);
      n++;
    end while (av_rsp.waitrequest !== 1'b0);
    rd = av_rsp.readdata;
    av_req <= '0;
    check("bus wait cycles", 2, n);
  endtask
  task automatic wl(output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (line_start !== 1'b1 && c < 7000);
  endtask
  task automatic t_idle;
    repeat (6000) @(posedge clk);
    check("lines idle", 0, nls);
    check("gate idle", 0, frame_valid);
    av(4'hf, 1'b0, '0);
    check("unmapped", 0, rd);
    av(lsa_pkg::ADDR_PERIOD, 1'b0, '0);
    check("period rst", lsa_pkg::PERIOD_RST, rd);
  endtask
  task automatic t_free;
    int c;
    int lo;
    int hi;
    int n0;
    av(lsa_pkg::ADDR_FRAME_CFG, 1'b1, '0);
    av(lsa_pkg::ADDR_LINE_CFG, 1'b1, '0);
    av(lsa_pkg::ADDR_HEIGHT, 1'b1, 32'h2);
    av(lsa_pkg::ADDR_PERIOD, 1'b1, 32'h1);
    av(lsa_pkg::ADDR_CMD, 1'b1, 32'h1);
    repeat (3) @(posedge clk);
    check("gate on start", 1, frame_valid);
    wl(c);
    wl(c);
    check("clamped period", 1, c >= lsa_pkg::MIN_PERIOD_CYC && c <= lsa_pkg::MIN_PERIOD_CYC + 1);
    lo = 0;
    hi = 0;
    repeat (8) begin
      if (frame_valid !== 1'b1) lo = 1;
      else if (lo == 1) hi = 1;
      @(posedge clk);
    end
    check("frame close", 1, lo);
    check("frame reopen", 1, hi);
    av(lsa_pkg::ADDR_CMD, 1'b1, 32'h2);
    n0 = nls;
    repeat (12000) @(posedge clk);
    check("lines stopped", n0, nls);
    check("gate stopped", 0, frame_valid);
    av(lsa_pkg::ADDR_LINES, 1'b0, '0);
    check("lines total", nls, rd);
  endtask
  task automatic t_ext_line;
    int n0;
    av(lsa_pkg::ADDR_HEIGHT, 1'b1, 32'h64);
    for (int k = 0; k < 3; k++) begin
      av(lsa_pkg::ADDR_LINE_CFG, 1'b1, {27'h0, 2'b11, 3'(k)});
      av(lsa_pkg::ADDR_CMD, 1'b1, 32'h1);
      n0 = nls;
      lsa_trig_src_inst.drive(1'b1, 1'b1, 50);
      lsa_trig_src_inst.drive(1'b1, 1'b0, 300);
      check("short pulse", n0, nls);
      lsa_trig_src_inst.drive(1'b0, 1'b1, 150);
      lsa_trig_src_inst.drive(1'b0, 1'b0, 300);
      check("other line", n0, nls);
      lsa_trig_src_inst.drive(1'b1, 1'b1, 150);
      lsa_trig_src_inst.drive(1'b1, 1'b0, 300);
      check("edge lines", n0 + ((k == 2) ? 2 : 1), nls);
      av(lsa_pkg::ADDR_CMD, 1'b1, 32'h2);
    end
    n0 = nls;
    lsa_trig_src_inst.drive(1'b1, 1'b1, 150);
    lsa_trig_src_inst.drive(1'b1, 1'b0, 300);
    check("line stopped", n0, nls);
  endtask
  task automatic t_ext_frame;
    logic [4:0] hi_exp;
    logic [4:0] lo_exp;
    // per activation code: gate seen after the rise, then after the fall
    hi_exp = 5'h0d;
    lo_exp = 5'h17;
    av(lsa_pkg::ADDR_LINE_CFG, 1'b1, '0);
    for (int k = 0; k < 5; k++) begin
      av(lsa_pkg::ADDR_FRAME_CFG, 1'b1, {27'h0, 2'b10, 3'(k)});
      av(lsa_pkg::ADDR_CMD, 1'b1, 32'h1);
      repeat (150) @(posedge clk);
      check("gate no edge", 0, frame_valid);
      lsa_trig_src_inst.drive(1'b0, 1'b1, 150);
      check("gate in high", hi_exp[k], frame_valid);
      lsa_trig_src_inst.drive(1'b0, 1'b0, 150);
      check("gate in low", lo_exp[k], frame_valid);
      av(lsa_pkg::ADDR_CMD, 1'b1, 32'h2);
    end
    av(lsa_pkg::ADDR_FRAME_CFG, 1'b1, {27'h0, 2'b11, lsa_pkg::ACT_RISE});
    av(lsa_pkg::ADDR_CMD, 1'b1, 32'h1);
    lsa_trig_src_inst.drive(1'b0, 1'b1, 150);
    check("gate other line", 0, frame_valid);
    lsa_trig_src_inst.drive(1'b1, 1'b1, 150);
    check("gate line b", 1, frame_valid);
    lsa_trig_src_inst.drive(1'b0, 1'b0, 1);
    lsa_trig_src_inst.drive(1'b1, 1'b0, 1);
    av(lsa_pkg::ADDR_CMD, 1'b1, 32'h2);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    av_req = '0;
    bad_count = 0;
    n_tests = 0;
    nls = 0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    t_idle();
    t_free();
    t_ext_line();
    t_ext_frame();
    summarize();
  end
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    summarize();
  end
endmodule
`default_nettype wire
